// ---- rtl/idp_pkg.sv ----
package idp_pkg;
   localparam int AW = 8;
   localparam int STR_N = 34;
   typedef logic [7:0] idx_t;
   localparam idx_t W_CFG = 8'h00, W_CYL = 8'h01, W_HEAD = 8'h03, W_SPT = 8'h06;
   localparam idx_t W_CAPH = 8'h07, W_CAPL = 8'h08, W_SER0 = 8'h0a, W_SER9 = 8'h13;
   localparam idx_t W_FW0 = 8'h17, W_MOD19 = 8'h2e, W_MMAX = 8'h2f, W_CAPS = 8'h31;
   localparam idx_t W_PIO = 8'h33, W_VALID = 8'h35, W_CCYL = 8'h36, W_CHEAD = 8'h37;
   localparam idx_t W_CSPT = 8'h38, W_CCAPL = 8'h39, W_CCAPH = 8'h3a, W_MCUR = 8'h3b;
   localparam idx_t W_LBAL = 8'h3c, W_LBAH = 8'h3d, W_DMA = 8'h3f, W_APIO = 8'h40;
   localparam idx_t W_DMIN = 8'h41, W_DREC = 8'h42, W_PNFC = 8'h43, W_PRDY = 8'h44;
   localparam idx_t SER_OFS = 8'h0a, FWM_OFS = 8'h0d;
   localparam logic [15:0] CFG_REMOV = 16'h848a, CFG_FIXED = 16'h045a;
   localparam logic [15:0] W53_VAL = 16'h0007, PAD2 = 16'h2020;
   localparam logic [7:0] W51_HI = 8'h02;
   localparam int B49_DMA = 8, B49_LBA = 9, B49_IORDY = 11, B59_VALID = 8;
   localparam logic [1:0] MODE_MAX = 2'h2;
   localparam int C_FIXED = 0, C_IORDY = 1, C_PIO = 2, C_DMAX = 4, C_DSUP = 6;
   localparam int C_DSEL = 7, C_DSEN = 9, C_PIO3 = 10, C_PIO4 = 11, C_MCUR = 16, C_MMAX = 24;
   localparam logic [AW-1:0] A_CTRL = 8'h00, A_GDEF = 8'h04, A_GCUR = 8'h08, A_CAP = 8'h0c;
   localparam logic [AW-1:0] A_LBA = 8'h10, A_DTIM = 8'h14, A_PTIM = 8'h18, A_STAT = 8'h1c;
   localparam logic [AW-1:0] A_STR = 8'h40, A_STR_END = 8'hc8;
   localparam logic [31:0] CTRL_RST = 32'h0100_0c02;
   localparam logic [1:0] RESP_OK = 2'h0, RESP_ERR = 2'h2;
   localparam logic [3:0] SEL_STR = 4'h8, SEL_NONE = 4'hf;
   typedef struct packed {
      logic          valid;
      idx_t          index;
   } idp_req_t;
   typedef struct packed {
      logic          valid;
      logic [15:0]   data;
   } idp_rsp_t;
   typedef struct packed {
      logic          awvalid;
      logic [AW-1:0] awaddr;
      logic          wvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bready;
      logic          arvalid;
      logic [AW-1:0] araddr;
      logic          rready;
   } idp_axi_m_t;
   typedef struct packed {
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } idp_axi_s_t;
   typedef struct packed {
      logic [7:0][31:0]       rg;
      logic [STR_N-1:0][15:0] str;
      logic                   aw_got;
      logic                   w_got;
      logic [AW-1:0]          awaddr;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      idp_rsp_t               rsp;
      logic [15:0]            rd_count;
      idx_t                   last_idx;
   } idp_state_t;
endpackage : idp_pkg

// ---- rtl/idp_identify_block.sv ----
`timescale 1ns/1ns
`default_nettype none
module idp_identify_block
   import idp_pkg::*;
#(
   parameter int ADDR_W = AW
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire idp_axi_m_t axi_m,
   output var  idp_axi_s_t axi_s,
   input  wire idp_req_t   id_req,
   output var  idp_rsp_t   id_rsp
);
   if (ADDR_W != AW) begin : g_chk
      $error("idp_identify_block: ADDR_W must equal the package address width");
   end

   idp_state_t r;
   idp_state_t next_r;

   // register decode shared by the write and read paths
   function automatic logic [3:0] reg_sel(input logic [AW-1:0] a);
      if (a[1:0] != 2'h0) begin
         return SEL_NONE;
      end else if (a < A_STR) begin
         return (a <= A_STAT) ? {1'b0, a[4:2]} : SEL_NONE;
      end else if (a < A_STR_END) begin
         return SEL_STR;
      end else begin
         return SEL_NONE;
      end
   endfunction : reg_sel

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            m[8*b +: 8] = d[8*b +: 8];
         end
      end
      return m;
   endfunction : merge

   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a : b;
   endfunction : max16

   logic [31:0] ctrl;
   logic [1:0]  dmax;
   logic [1:0]  dsel;
   logic        dma1;
   logic        pio34;
   logic [31:0] cur_cap;
   assign ctrl    = r.rg[0];
   assign dmax    = (ctrl[C_DMAX +: 2] > MODE_MAX) ? MODE_MAX : ctrl[C_DMAX +: 2];
   assign dsel    = ctrl[C_DSEL +: 2];
   assign dma1    = ctrl[C_DSUP] && (dmax != 2'h0);
   assign pio34   = ctrl[C_PIO3] | ctrl[C_PIO4];
   assign cur_cap = 32'(r.rg[2][15:0]) * 32'(r.rg[2][23:16]) * 32'(r.rg[2][31:24]);

   // handshakes are combinational; one write and one read held at a time
   always_comb begin
      axi_s.awready = !r.aw_got && !r.bvalid;
      axi_s.wready  = !r.w_got && !r.bvalid;
      axi_s.bvalid  = r.bvalid;
      axi_s.bresp   = r.bresp;
      axi_s.arready = !r.rvalid;
      axi_s.rvalid  = r.rvalid;
      axi_s.rdata   = r.rdata;
      axi_s.rresp   = r.rresp;
      id_rsp        = r.rsp;
   end

   always_comb begin
      logic [15:0] w;
      logic [3:0]  sel;
      logic [AW-1:0] sofs;
      logic [15:0] w65;
      logic [15:0] w68;
      idx_t        ix;
      w      = '0;
      sel    = SEL_NONE;
      sofs   = '0;
      ix     = id_req.index;
      w65    = dma1 ? r.rg[5][15:0] : 16'h0000;
      w68    = pio34 ? r.rg[6][31:16] : 16'h0000;
      next_r = r;
      if (axi_m.awvalid && axi_s.awready) begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = axi_m.awaddr;
      end
      if (axi_m.wvalid && axi_s.wready) begin
         next_r.w_got = 1'b1;
         next_r.wdata = axi_m.wdata;
         next_r.wstrb = axi_m.wstrb;
      end
      if (r.aw_got && r.w_got) begin
         sel            = reg_sel(r.awaddr);
         sofs           = AW'((r.awaddr - A_STR) >> 2);
         next_r.aw_got  = 1'b0;
         next_r.w_got   = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = RESP_OK;
         if (sel == SEL_STR) begin
            if (r.wstrb[0]) begin
               next_r.str[sofs][7:0] = r.wdata[7:0];
            end
            if (r.wstrb[1]) begin
               next_r.str[sofs][15:8] = r.wdata[15:8];
            end
         end else if (sel < 4'h7) begin
            next_r.rg[sel[2:0]] = merge(r.rg[sel[2:0]], r.wdata, r.wstrb);
         end else begin
            next_r.bresp = RESP_ERR;
         end
      end
      if (r.bvalid && axi_m.bready) begin
         next_r.bvalid = 1'b0;
      end
      if (axi_m.arvalid && axi_s.arready) begin
         sel           = reg_sel(axi_m.araddr);
         sofs          = AW'((axi_m.araddr - A_STR) >> 2);
         next_r.rvalid = 1'b1;
         next_r.rresp  = RESP_OK;
         next_r.rdata  = '0;
         if (sel == SEL_STR) begin
            next_r.rdata = {16'h0000, r.str[sofs]};
         end else if (sel == 4'h7) begin
            next_r.rdata = {r.rd_count, 8'h00, r.last_idx};
         end else if (sel != SEL_NONE) begin
            next_r.rdata = r.rg[sel[2:0]];
         end else begin
            next_r.rresp = RESP_ERR;
         end
      end else if (r.rvalid && axi_m.rready) begin
         next_r.rvalid = 1'b0;
      end
      // identify word generator, answered one cycle after the request
      if (ix >= W_SER0 && ix <= W_SER9) begin
         w = r.str[ix - SER_OFS];
      end else if (ix >= W_FW0 && ix <= W_MOD19) begin
         w = r.str[ix - FWM_OFS];
      end else begin
         case (ix)
            W_CFG:   w = ctrl[C_FIXED] ? CFG_FIXED : CFG_REMOV;
            W_CYL:   w = r.rg[1][15:0];
            W_HEAD:  w = {8'h00, r.rg[1][23:16]};
            W_SPT:   w = {8'h00, r.rg[1][31:24]};
            W_CAPH:  w = r.rg[3][31:16];
            W_CAPL:  w = r.rg[3][15:0];
            W_MMAX:  w = {8'h00, ctrl[C_MMAX +: 8]};
            W_CAPS: begin
               w[B49_IORDY] = ctrl[C_IORDY];
               w[B49_LBA]   = 1'b1;
               w[B49_DMA]   = 1'b1;
            end
            W_PIO: begin
               w = {W51_HI, 6'h00, ctrl[C_PIO +: 2]};
               if (ctrl[C_PIO +: 2] > MODE_MAX) begin
                  w[1:0] = MODE_MAX;
               end
            end
            W_VALID: w = W53_VAL;
            W_CCYL:  w = r.rg[2][15:0];
            W_CHEAD: w = {8'h00, r.rg[2][23:16]};
            W_CSPT:  w = {8'h00, r.rg[2][31:24]};
            W_CCAPL: w = cur_cap[15:0];
            W_CCAPH: w = cur_cap[31:16];
            W_MCUR: begin
               // only zero or one may be reported; any nonzero setting reads as one
               w[B59_VALID] = 1'b1;
               w[0]         = |ctrl[C_MCUR +: 8];
            end
            W_LBAL:  w = r.rg[4][15:0];
            W_LBAH:  w = r.rg[4][31:16];
            W_DMA: begin
               if (ctrl[C_DSEN] && ctrl[C_DSUP] && dsel <= dmax) begin
                  w[8 + dsel] = 1'b1;
               end
               if (ctrl[C_DSUP]) begin
                  w[2:0] = (dmax == 2'h0) ? 3'h1 : (dmax == 2'h1) ? 3'h3 : 3'h7;
               end
            end
            W_APIO:  w = {14'h0000, ctrl[C_PIO4], ctrl[C_PIO3]};
            W_DMIN:  w = w65;
            W_DREC:  w = dma1 ? max16(r.rg[5][31:16], w65) : 16'h0000;
            W_PNFC:  w = pio34 ? max16(r.rg[6][15:0], w68) : 16'h0000;
            W_PRDY:  w = w68;
            default: w = '0;
         endcase
      end
      next_r.rsp.valid = id_req.valid;
      if (id_req.valid) begin
         next_r.rsp.data = w;
         next_r.rd_count = r.rd_count + 16'h0001;
         next_r.last_idx = ix;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r       <= '0;
         r.rg[0] <= CTRL_RST;
         r.str   <= {STR_N{PAD2}};
      end else begin
         r <= next_r;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ask(idx_t n);
      id_req.valid && id_req.index == n;
   endsequence

   // write and read steps of the register bus
   sequence s_wr_held;
      r.aw_got && r.w_got;
   endsequence

   sequence s_wr_done;
      axi_s.bvalid && axi_m.bready;
   endsequence

   sequence s_rd_take;
      axi_m.arvalid && axi_s.arready;
   endsequence

   sequence s_rd_done;
      axi_s.rvalid && axi_m.rready;
   endsequence

   a_word0_mode: assert property (s_ask(W_CFG) |=> id_rsp.valid &&
      id_rsp.data == ($past(r.rg[0][C_FIXED]) ? CFG_FIXED : CFG_REMOV))
      else $error("word 0 wrong for mode");
   a_caps_bits: assert property (s_ask(W_CAPS) |=> id_rsp.data[13:8] ==
      {2'b00, $past(r.rg[0][C_IORDY]), 1'b0, 2'b11})
      else $error("word 49 bits wrong");
   a_lba_dma_bits: assert property (s_ask(W_CAPS) |=> id_rsp.data[9] && id_rsp.data[8])
      else $error("word 49 lba or dma bit clear");
   a_pio_hi_byte: assert property (s_ask(W_PIO) |=> id_rsp.data[15:8] == W51_HI
      && id_rsp.data[7:0] <= 8'h02)
      else $error("word 51 wrong");
   a_valid_word: assert property (s_ask(W_VALID) |=> id_rsp.data == W53_VAL)
      else $error("word 53 wrong");
   a_multi_set: assert property (s_ask(W_MCUR) |=> id_rsp.data[15:9] == 7'h00
      && id_rsp.data[8] && id_rsp.data[7:0] <= 8'h01)
      else $error("word 59 wrong");
   a_dma_onehot: assert property (s_ask(W_DMA) |=> $onehot0(id_rsp.data[15:8])
      && id_rsp.data[15:11] == 5'h00)
      else $error("word 63 selection not one-hot");
   a_dma_cumul: assert property (s_ask(W_DMA) |=> id_rsp.data[7:3] == 5'h00 &&
      (id_rsp.data[2:0] == 3'h0 || id_rsp.data[2:0] == 3'h1 ||
       id_rsp.data[2:0] == 3'h3 || id_rsp.data[2:0] == 3'h7))
      else $error("word 63 support not cumulative");
   a_dmin_zero: assert property (s_ask(W_DMIN) ##0 !dma1 |=> id_rsp.data == 16'h0000)
      else $error("word 65 nonzero without dma mode 1");
   a_drec_order: assert property (s_ask(W_DREC) ##0 dma1 |=>
      id_rsp.data >= $past(r.rg[5][15:0]))
      else $error("word 66 below word 65");
   a_pio_order: assert property (s_ask(W_PNFC) ##0 pio34 |=>
      id_rsp.data >= $past(r.rg[6][31:16]))
      else $error("word 67 below word 68");
   a_prdy_zero: assert property (s_ask(W_PRDY) ##0 !pio34 |=> id_rsp.data == 16'h0000)
      else $error("word 68 nonzero without pio 3 or 4");
   a_reserved_zero: assert property (s_ask(8'h45) |=> id_rsp.data == 16'h0000)
      else $error("reserved word nonzero");
   a_cap_words: assert property (s_ask(W_CAPH) |=>
      id_rsp.data == $past(r.rg[3][31:16]))
      else $error("word 7 not capacity high half");
   a_write_resp: assert property (r.aw_got && r.w_got |=> axi_s.bvalid)
      else $error("write response missing");

   // identify port timing and plain words
   a_rsp_follows: assert property (id_req.valid |=> id_rsp.valid)
      else $error("identify answer missing");
   a_rsp_idle: assert property (!id_req.valid |=> !id_rsp.valid)
      else $error("identify answer without request");
   a_rsp_stands: assert property (!id_req.valid |=> $stable(id_rsp.data))
      else $error("identify data changed without request");
   a_count_step: assert property (id_req.valid |=>
      r.rd_count == $past(r.rd_count) + 16'h0001)
      else $error("request count not advanced");
   a_cyl_word: assert property (s_ask(W_CYL) |=>
      id_rsp.data == $past(r.rg[1][15:0]))
      else $error("word 1 not default cylinders");
   a_head_word: assert property (s_ask(W_HEAD) |=>
      id_rsp.data == {8'h00, $past(r.rg[1][23:16])})
      else $error("word 3 not default heads");
   a_spt_word: assert property (s_ask(W_SPT) |=>
      id_rsp.data == {8'h00, $past(r.rg[1][31:24])})
      else $error("word 6 not default sectors per track");
   a_cap_low: assert property (s_ask(W_CAPL) |=>
      id_rsp.data == $past(r.rg[3][15:0]))
      else $error("word 8 not capacity low half");
   a_serial_words: assert property (id_req.valid && id_req.index >= W_SER0 && id_req.index <= W_SER9 |=>
      id_rsp.data == $past(r.str[id_req.index - SER_OFS]))
      else $error("serial word not from string store");
   a_model_words: assert property (id_req.valid && id_req.index >= W_FW0 && id_req.index <= W_MOD19 |=>
      id_rsp.data == $past(r.str[id_req.index - FWM_OFS]))
      else $error("firmware or model word not from string store");
   a_multi_max: assert property (s_ask(W_MMAX) |=>
      id_rsp.data == {8'h00, $past(ctrl[C_MMAX +: 8])})
      else $error("word 47 not the multiple limit");
   a_cur_cyl: assert property (s_ask(W_CCYL) |=>
      id_rsp.data == $past(r.rg[2][15:0]))
      else $error("word 54 not current cylinders");
   a_cur_head: assert property (s_ask(W_CHEAD) |=>
      id_rsp.data == {8'h00, $past(r.rg[2][23:16])})
      else $error("word 55 not current heads");
   a_cur_spt: assert property (s_ask(W_CSPT) |=>
      id_rsp.data == {8'h00, $past(r.rg[2][31:24])})
      else $error("word 56 not current sectors per track");
   a_cap_prod: assert property (s_ask(W_CCAPL) |=>
      id_rsp.data == $past(cur_cap[15:0]))
      else $error("word 57 not capacity product low half");
   a_cur_cap: assert property (s_ask(W_CCAPH) |=>
      id_rsp.data == $past(cur_cap[31:16]))
      else $error("word 58 not capacity product high half");
   a_lba_low: assert property (s_ask(W_LBAL) |=>
      id_rsp.data == $past(r.rg[4][15:0]))
      else $error("word 60 not block count low half");
   a_lba_high: assert property (s_ask(W_LBAH) |=>
      id_rsp.data == $past(r.rg[4][31:16]))
      else $error("word 61 not block count high half");

   // mode and timing words
   a_mode_ceiling: assert property (s_ask(W_DMA) |=>
      id_rsp.data[15:11] == 5'h00 && id_rsp.data[7:3] == 5'h00)
      else $error("word 63 shows a mode above 2");
   a_adv_pio: assert property (s_ask(W_APIO) |=>
      id_rsp.data[15:2] == 14'h0000 && id_rsp.data[1:0] == $past({ctrl[C_PIO4], ctrl[C_PIO3]}))
      else $error("word 64 wrong");
   a_sel_shown: assert property (s_ask(W_DMA) ##0 ctrl[C_DSEN] && ctrl[C_DSUP] && dsel <= dmax |=>
      id_rsp.data[15:8] == 8'(1 << $past(dsel)))
      else $error("word 63 selected mode missing");
   a_dmin_value: assert property (s_ask(W_DMIN) ##0 dma1 |=>
      id_rsp.data == $past(r.rg[5][15:0]))
      else $error("word 65 not the programmed minimum");
   a_drec_zero: assert property (s_ask(W_DREC) ##0 !dma1 |=> id_rsp.data == 16'h0000)
      else $error("word 66 nonzero without dma mode 1");
   a_pnfc_zero: assert property (s_ask(W_PNFC) ##0 !pio34 |=> id_rsp.data == 16'h0000)
      else $error("word 67 nonzero without pio 3 or 4");
   a_prdy_value: assert property (s_ask(W_PRDY) ##0 pio34 |=>
      id_rsp.data == $past(r.rg[6][31:16]))
      else $error("word 68 not the programmed ready time");

   // register bus handshakes, write landing and address decode
   a_read_resp: assert property (s_rd_take |=> axi_s.rvalid)
      else $error("read response missing");
   a_read_clear: assert property (s_rd_done |=> !axi_s.rvalid)
      else $error("read response not released");
   a_write_clear: assert property (s_wr_done |=> !axi_s.bvalid)
      else $error("write response not released");
   a_rvalid_stands: assert property (axi_s.rvalid && !axi_m.rready |=>
      axi_s.rvalid && $stable(axi_s.rdata) && $stable(axi_s.rresp))
      else $error("read response dropped before taken");
   a_bvalid_stands: assert property (axi_s.bvalid && !axi_m.bready |=>
      axi_s.bvalid && $stable(axi_s.bresp))
      else $error("write response dropped before taken");
   a_wr_lands: assert property (s_wr_held ##0 r.awaddr == A_CTRL && r.wstrb == 4'hf |=>
      r.rg[0] == $past(r.wdata))
      else $error("control write did not land");
   a_bad_read: assert property (s_rd_take ##0 axi_m.araddr[1:0] != 2'h0 |=>
      axi_s.rresp == RESP_ERR && axi_s.rdata == 32'h0000_0000)
      else $error("misaligned read not refused");
   a_stat_write: assert property (s_wr_held ##0 r.awaddr == A_STAT |=> axi_s.bresp == RESP_ERR)
      else $error("status write not refused");
   a_str_upper: assert property (s_rd_take ##0 axi_m.araddr >= A_STR && axi_m.araddr < A_STR_END |=>
      axi_s.rdata[31:16] == 16'h0000)
      else $error("string word upper half not zero");
endmodule : idp_identify_block
`default_nettype wire

// ---- tb/idp_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module idp_host_model
   import idp_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        go,
   input  wire idx_t        idx,
   input  wire idp_rsp_t    rsp,
   output var  idp_req_t    req,
   output var  logic [15:0] word,
   output var  logic        done
);
   // only single identify reads are issued; no data transfer timing is driven here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req  <= '0;
         word <= '0;
         done <= 1'b0;
      end else begin
         req.valid <= go;
         // a released index must not keep its old value
         req.index <= go ? idx : ~req.index;
         done      <= rsp.valid;
         if (rsp.valid) word <= rsp.data;
      end
   end
endmodule : idp_host_model
`default_nettype wire

// ---- tb/test_identify_parameter_block.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_identify_parameter_block
   import idp_pkg::*;
;
   localparam idx_t CW [12] = '{8'd0, 8'd47, 8'd49, 8'd51, 8'd53, 8'd59, 8'd63, 8'd64, 8'd65, 8'd66, 8'd67, 8'd68};
   localparam idx_t RSV [11] = '{8'd2, 8'd4, 8'd5, 8'd9, 8'd20, 8'd22, 8'd48, 8'd50, 8'd62, 8'd69, 8'hff};
   localparam int   SI [6] = '{0, 9, 10, 13, 14, 33};
   logic        aclk, aresetn, go, done;
   idx_t        idx, last;
   idp_axi_m_t  m;
   idp_axi_s_t  s;
   idp_req_t    req;
   idp_rsp_t    rsp;
   logic [15:0] word;
   logic [31:0] ctrl, dt, pt, g, c, cap, lba, p;
   int          errors, checks_done, n_req;
   logic [3:0]  strb;

   idp_identify_block #(.ADDR_W(8)) i_idp_identify_block (.aclk(aclk), .aresetn(aresetn), .axi_m(m),
      .axi_s(s), .id_req(req), .id_rsp(rsp));
   idp_host_model i_idp_host_model (.aclk(aclk), .aresetn(aresetn), .go(go), .idx(idx), .rsp(rsp),
      .req(req), .word(word), .done(done));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      m <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: strb, bready: 1'b1, default: '0};
      for (n = 0; n < 200; n++) begin
         #1;
         ta = m.awvalid && s.awready;
         tw = m.wvalid && s.wready;
         tb = m.bready && s.bvalid;
         r = s.bresp;
         @(posedge aclk);
         if (ta) m.awvalid <= 1'b0;
         if (tw) m.wvalid <= 1'b0;
         if (tb) begin
            m.bready <= 1'b0;
            break;
         end
      end
      if (n == 200) begin
         errors++;
         close_out();
      end
      chk(32'(r), 32'(er));
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      logic ta, tb;
      logic [1:0] r;
      logic [31:0] d;
      @(posedge aclk);
      m <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
      for (n = 0; n < 200; n++) begin
         #1;
         ta = m.arvalid && s.arready;
         tb = m.rready && s.rvalid;
         d = s.rdata;
         r = s.rresp;
         @(posedge aclk);
         if (ta) m.arvalid <= 1'b0;
         if (tb) begin
            m.rready <= 1'b0;
            break;
         end
      end
      if (n == 200) begin
         errors++;
         close_out();
      end
      chk(d, exp);
      chk(32'(r), 32'(er));
   endtask : axi_rd

   task automatic id_chk(input idx_t i, input logic [15:0] exp);
      int n;
      @(posedge aclk);
      go <= 1'b1;
      idx <= i;
      @(posedge aclk);
      go <= 1'b0;
      n_req++;
      last = i;
      for (n = 0; n < 20; n++) begin
         #1;
         if (done === 1'b1) break;
         @(posedge aclk);
      end
      if (n == 20) begin
         errors++;
         close_out();
      end
      chk({16'h0, word}, {16'h0, exp});
   endtask : id_chk

   // expected control-derived words from the shadow of CTRL, DMA and PIO timing registers
   function automatic logic [15:0] exp_w(input idx_t w);
      logic [1:0] mx;
      logic       dma, pio;
      logic [2:0] sup, sel;
      mx = (ctrl[5:4] > 2'h2) ? 2'h2 : ctrl[5:4];
      dma = ctrl[6] && (mx != 2'h0);
      pio = ctrl[10] || ctrl[11];
      sup = ctrl[6] ? (3'b111 >> (2'h2 - mx)) : 3'h0;
      sel = (ctrl[6] && ctrl[9] && ctrl[8:7] <= mx) ? (3'h1 << ctrl[8:7]) : 3'h0;
      case (w)
         8'd0:    return ctrl[0] ? 16'h045a : 16'h848a;
         8'd47:   return {8'h00, ctrl[31:24]};
         8'd49:   return {4'h0, ctrl[1], 1'b0, 2'h3, 8'h00};
         8'd51:   return {8'h02, 6'h0, ((ctrl[3:2] > 2'h2) ? 2'h2 : ctrl[3:2])};
         8'd53:   return 16'h0007;
         8'd59:   return {8'h01, 7'h0, |ctrl[23:16]};
         8'd63:   return {5'h0, sel, 5'h0, sup};
         8'd64:   return {14'h0, ctrl[11], ctrl[10]};
         8'd65:   return dma ? dt[15:0] : 16'h0;
         8'd66:   return !dma ? 16'h0 : ((dt[31:16] < dt[15:0]) ? dt[15:0] : dt[31:16]);
         8'd67:   return !pio ? 16'h0 : ((pt[15:0] < pt[31:16]) ? pt[31:16] : pt[15:0]);
         8'd68:   return pio ? pt[31:16] : 16'h0;
         default: return 16'h0;
      endcase
   endfunction : exp_w

   initial begin
      m = '0;
      go = 1'b0;
      idx = '0;
      aresetn = 1'b0;
      errors = 0;
      checks_done = 0;
      n_req = 0;
      strb = 4'hf;
      last = '0;
      void'($urandom(32'he75b));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      ctrl = CTRL_RST;
      dt = '0;
      pt = '0;
      axi_rd(A_CTRL, CTRL_RST, RESP_OK);
      foreach (CW[k]) id_chk(CW[k], exp_w(CW[k]));
      id_chk(8'd10, 16'h2020);
      id_chk(8'd46, 16'h2020);
      $display("test reset image done");
      // first two passes are the all-ones and all-zeros corners, where every clamp is exercised
      for (int t = 0; t < 14; t++) begin
         ctrl = (t == 0) ? 32'hffff_ffff : (t == 1) ? 32'h0 : $urandom;
         dt = $urandom;
         pt = $urandom;
         axi_wr(A_CTRL, ctrl, RESP_OK);
         axi_wr(A_DTIM, dt, RESP_OK);
         axi_wr(A_PTIM, pt, RESP_OK);
         foreach (CW[k]) id_chk(CW[k], exp_w(CW[k]));
      end
      $display("test modes and timing done");
      for (int t = 0; t < 4; t++) begin
         g = $urandom;
         c = $urandom;
         cap = $urandom;
         lba = $urandom;
         p = 32'(c[15:0]) * 32'(c[23:16]) * 32'(c[31:24]);
         axi_wr(A_GDEF, g, RESP_OK);
         axi_wr(A_GCUR, c, RESP_OK);
         axi_wr(A_CAP, cap, RESP_OK);
         axi_wr(A_LBA, lba, RESP_OK);
         id_chk(8'd1, g[15:0]);
         id_chk(8'd3, {8'h0, g[23:16]});
         id_chk(8'd6, {8'h0, g[31:24]});
         id_chk(8'd7, cap[31:16]);
         id_chk(8'd8, cap[15:0]);
         id_chk(8'd54, c[15:0]);
         id_chk(8'd55, {8'h0, c[23:16]});
         id_chk(8'd56, {8'h0, c[31:24]});
         id_chk(8'd57, p[15:0]);
         id_chk(8'd58, p[31:16]);
         id_chk(8'd60, lba[15:0]);
         id_chk(8'd61, lba[31:16]);
      end
      // byte lanes 0 and 2 only: the other lanes must keep the last block count
      strb = 4'h5;
      axi_wr(A_LBA, 32'hffff_ffff, RESP_OK);
      strb = 4'hf;
      id_chk(8'd60, {lba[15:8], 8'hff});
      id_chk(8'd61, {lba[31:24], 8'hff});
      $display("test geometry done");
      foreach (SI[k]) begin
         g = $urandom;
         axi_wr(A_STR + 8'(4 * SI[k]), g, RESP_OK);
         axi_rd(A_STR + 8'(4 * SI[k]), {16'h0, g[15:0]}, RESP_OK);
         id_chk((SI[k] < 10) ? 8'(10 + SI[k]) : 8'(13 + SI[k]), g[15:0]);
      end
      id_chk(8'd45, 16'h2020);
      $display("test strings done");
      foreach (RSV[k]) id_chk(RSV[k], 16'h0);
      axi_wr(A_STAT, 32'hffff_ffff, RESP_ERR);
      axi_wr(A_STR_END, 32'h1234_5678, RESP_ERR);
      axi_rd(8'h02, 32'h0, RESP_ERR);
      axi_rd(8'h20, 32'h0, RESP_ERR);
      axi_rd(A_STAT, {16'(n_req), 8'h00, last}, RESP_OK);
      $display("test reserved and refused done");
      close_out();
   end
endmodule : test_identify_parameter_block
`default_nettype wire
